// File: rtl/atsp_pkg.sv
// Shared constants for the ten-bit async serial port
package atsp_pkg;
    // Register byte offsets
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
    // Control register fields
    localparam int CTRL_TX_DONE = 0;
    localparam int CTRL_RX_DONE = 1;
    localparam int CTRL_NINTH = 2;
    localparam int CTRL_MPROC = 3;
    localparam int CTRL_REN = 4;
    localparam int CTRL_DBL = 5;
    localparam int CTRL_TX_SRC = 6;
    localparam int CTRL_RX_SRC = 7;
    localparam int CTRL_W = 8;
    // Interrupt status fields
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_W = 2;
    // Bit timing
    localparam logic [3:0] SAMPLE_A = 4'h6;
    localparam logic [3:0] SAMPLE_B = 4'h7;
    localparam logic [3:0] SAMPLE_C = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [3:0] TX_BITS = 4'hA;
    localparam logic [8:0] RX_PRELOAD = 9'h1FF;
endpackage

// File: rtl/atsp_rx_vote.sv
// Three-sample majority vote for the receive line
`timescale 1ns/1ps
`default_nettype none
module atsp_rx_vote
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sampling
    input wire logic rxd_i,
    input wire logic tick_i,
    input wire logic [3:0] phase_i,
    // Result
    output logic bit_o
);
    logic [2:0] smp_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            smp_reg <= 3'h7;
        else if (tick_i && (phase_i == atsp_pkg::SAMPLE_A || phase_i == atsp_pkg::SAMPLE_B
                 || phase_i == atsp_pkg::SAMPLE_C))
            smp_reg <= {smp_reg[1:0], rxd_i};
    end

    assign bit_o = (smp_reg[0] & smp_reg[1]) | (smp_reg[1] & smp_reg[2]) | (smp_reg[0] & smp_reg[2]);
endmodule
`default_nettype wire

// File: rtl/atsp_tick_gen.sv
// Oversample tick selection and baud doubler
`timescale 1ns/1ps
`default_nettype none
module atsp_tick_gen
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Timer overflow ticks and selection
    input wire logic t1_ovf_i,
    input wire logic t2_ovf_i,
    input wire logic tx_src_i,
    input wire logic rx_src_i,
    input wire logic dbl_i,
    // Ticks out
    atsp_tick_if.src tick
);
    logic t1_half_reg;
    logic t2_half_reg;
    logic t1_tick;
    logic t2_tick;

    // Undoubled rate takes every second overflow
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            t1_half_reg <= 1'b0;
            t2_half_reg <= 1'b0;
        end
        else
        begin
            if (t1_ovf_i)
                t1_half_reg <= ~t1_half_reg;
            if (t2_ovf_i)
                t2_half_reg <= ~t2_half_reg;
        end
    end

    assign t1_tick = t1_ovf_i & (dbl_i | t1_half_reg);
    assign t2_tick = t2_ovf_i & (dbl_i | t2_half_reg);
    assign tick.tx_tick = tx_src_i ? t2_tick : t1_tick;
    assign tick.rx_tick = rx_src_i ? t2_tick : t1_tick;
endmodule
`default_nettype wire

// File: rtl/atsp_tick_if.sv
// Sixteen-per-bit oversample tick bundle between the tick divider and the port core
`timescale 1ns/1ps
`default_nettype none
interface atsp_tick_if;
    logic tx_tick;
    logic rx_tick;
    modport src (output tx_tick, output rx_tick);
    modport dst (input tx_tick, input rx_tick);
endinterface
`default_nettype wire

// File: rtl/atsp_uart.sv
// Ten-bit async serial port with Wishbone registers
// What this block does
// - Start low, eight data LSB first, stop high
// - Received stop bit lands in ninth-bit flag
// - Rate from timer 1, timer 2, or split
// - Data write loads marker one, requests send
// - Send starts after next divide-by-16 rollover
// - Start bit, then data enable, then shifting
// - Zeros shift in; marker detect ends send
// - Send ends at tenth rollover after write
// - Receive starts on sampled falling line edge
// - Edge resets counter, preloads ones
// - Majority of samples seven, eight, nine
// - Nonzero start bit restarts the hunt
// - Shift in from right, nine-bit register
// - Accept only if done clear and, with multiprocessor check on, stop high
// - Always resume hunting after final shift
// - Interrupt is receive-done OR transmit-done
// - Doubler bit doubles the bit rate
// - Software writes to flags act like hardware on serial_irq_o only
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module atsp_uart
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Timer overflow ticks
    input wire logic t1_ovf_i,
    input wire logic t2_ovf_i,
    // Serial line
    input wire logic rxd_i,
    output logic txd_o,
    // Interrupts
    output logic irq_o,
    output logic serial_irq_o
);
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_START = 2'b10, TX_DATA = 2'b11} atsp_tx_t;
    typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10} atsp_rx_t;

    atsp_tick_if tick ();

    logic [7:0] serial_data_buffer;
    logic [atsp_pkg::CTRL_W-1:0] serial_control_reg;
    logic [atsp_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [atsp_pkg::IRQ_W-1:0] irq_mask_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic wr_stb;
    logic rd_stb;
    logic data_wr;
    logic ctrl_wr;
    logic tx_done_set;
    logic rx_accept;

    atsp_tx_t tx_state_reg;
    logic [3:0] tx_div_reg;
    logic [8:0] tx_shift_reg;
    logic [3:0] tx_bits_reg;
    logic txd_reg;
    logic tx_roll;

    atsp_rx_t rx_state_reg;
    logic [1:0] rxd_sync_reg;
    logic rxd_prev_reg;
    logic [3:0] rx_div_reg;
    logic [8:0] rx_shift_reg;
    logic rx_bit;
    logic rx_end_bit;

    logic tx_done_flag;
    logic rx_done_flag;
    logic multiproc_check_enable;
    logic rx_enable;
    logic baud_doubler;

    assign tx_done_flag = serial_control_reg[atsp_pkg::CTRL_TX_DONE];
    assign rx_done_flag = serial_control_reg[atsp_pkg::CTRL_RX_DONE];
    assign multiproc_check_enable = serial_control_reg[atsp_pkg::CTRL_MPROC];
    assign rx_enable = serial_control_reg[atsp_pkg::CTRL_REN];
    assign baud_doubler = serial_control_reg[atsp_pkg::CTRL_DBL];

    atsp_tick_gen u_tick
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t1_ovf_i(t1_ovf_i),
        .t2_ovf_i(t2_ovf_i),
        .tx_src_i(serial_control_reg[atsp_pkg::CTRL_TX_SRC]),
        .rx_src_i(serial_control_reg[atsp_pkg::CTRL_RX_SRC]),
        .dbl_i(baud_doubler),
        .tick(tick.src)
    );

    // Bus decode; one wait state, so ack comes the cycle after the request
    assign wr_stb = cyc_i & stb_i & we_i & ~ack_reg;
    assign rd_stb = cyc_i & stb_i & ~we_i & ~ack_reg;
    assign data_wr = wr_stb & sel_i[0] & (adr_i == atsp_pkg::ADDR_DATA);
    assign ctrl_wr = wr_stb & sel_i[0] & (adr_i == atsp_pkg::ADDR_CTRL);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= cyc_i & stb_i & ~ack_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_reg <= 32'h0000_0000;
        else if (rd_stb)
        begin
            unique case (adr_i)
                atsp_pkg::ADDR_DATA: dat_reg <= {24'h00_0000, serial_data_buffer};
                atsp_pkg::ADDR_CTRL: dat_reg <= {24'h00_0000, serial_control_reg};
                atsp_pkg::ADDR_IRQ_STAT: dat_reg <= {30'h0000_0000, irq_stat_reg};
                atsp_pkg::ADDR_IRQ_MASK: dat_reg <= {30'h0000_0000, irq_mask_reg};
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // Control register: hardware sets win over a software clear in the same cycle
    // Flags are plain bits, so software may raise them and serial_irq_o follows, but irq_o does not
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            serial_control_reg <= '0;
        else
        begin
            if (ctrl_wr)
                serial_control_reg <= dat_i[atsp_pkg::CTRL_W-1:0];
            if (tx_done_set)
                serial_control_reg[atsp_pkg::CTRL_TX_DONE] <= 1'b1;
            if (rx_accept)
            begin
                serial_control_reg[atsp_pkg::CTRL_RX_DONE] <= 1'b1;
                serial_control_reg[atsp_pkg::CTRL_NINTH] <= rx_end_bit;
            end
        end
    end

    // Interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end
        else
        begin
            if (wr_stb && sel_i[0] && adr_i == atsp_pkg::ADDR_IRQ_MASK)
                irq_mask_reg <= dat_i[atsp_pkg::IRQ_W-1:0];
            if (wr_stb && sel_i[0] && adr_i == atsp_pkg::ADDR_IRQ_STAT)
                irq_stat_reg <= irq_stat_reg & ~dat_i[atsp_pkg::IRQ_W-1:0];
            if (tx_done_set)
                irq_stat_reg[atsp_pkg::IRQ_TX] <= 1'b1;
            if (rx_accept)
                irq_stat_reg[atsp_pkg::IRQ_RX] <= 1'b1;
        end
    end

    assign irq_o = |(irq_stat_reg & irq_mask_reg);
    assign serial_irq_o = tx_done_flag | rx_done_flag;

    // Transmit path; divider free-runs so bits follow its rollover
    assign tx_roll = tick.tx_tick & (tx_div_reg == atsp_pkg::BIT_LAST);
    // Counter holds the rollovers already seen, so the tenth arrives while it reads nine
    assign tx_done_set = (tx_state_reg == TX_DATA) & tx_roll & (tx_shift_reg[8:1] == 8'h01)
                         & (tx_bits_reg == atsp_pkg::TX_BITS - 4'h1);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_div_reg <= 4'h0;
        else if (tick.tx_tick)
            tx_div_reg <= tx_div_reg + 4'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= 9'h000;
            tx_bits_reg <= 4'h0;
            txd_reg <= 1'b1;
        end
        else if (data_wr)
        begin
            // Write restarts any send in progress
            // A cut frame leaves the line high until the next rollover
            tx_shift_reg <= {1'b1, dat_i[7:0]};
            tx_state_reg <= TX_WAIT;
            tx_bits_reg <= 4'h0;
            txd_reg <= 1'b1;
        end
        else if (tx_roll)
        begin
            unique case (tx_state_reg)
                TX_IDLE:
                    txd_reg <= 1'b1;
                TX_WAIT:
                begin
                    tx_state_reg <= TX_START;
                    txd_reg <= 1'b0;
                    tx_bits_reg <= 4'h1;
                end
                TX_START:
                begin
                    tx_state_reg <= TX_DATA;
                    txd_reg <= tx_shift_reg[0];
                    tx_bits_reg <= tx_bits_reg + 4'h1;
                end
                TX_DATA:
                begin
                    tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                    tx_bits_reg <= tx_bits_reg + 4'h1;
                    if (tx_done_set)
                    begin
                        tx_state_reg <= TX_IDLE;
                        txd_reg <= 1'b1;
                    end
                    else
                        txd_reg <= tx_shift_reg[1];
                end
            endcase
        end
    end

    assign txd_o = txd_reg;

    // Receive path; line is a pin so it is synchronised first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rxd_sync_reg <= 2'b11;
            rxd_prev_reg <= 1'b1;
        end
        else
        begin
            rxd_sync_reg <= {rxd_sync_reg[0], rxd_i};
            if (tick.rx_tick)
                rxd_prev_reg <= rxd_sync_reg[1];
        end
    end

    // Vote sees the synchronised line, so samples lag the pin by two cycles
    atsp_rx_vote u_vote
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rxd_i(rxd_sync_reg[1]),
        .tick_i(tick.rx_tick),
        .phase_i(rx_div_reg),
        .bit_o(rx_bit)
    );

    // Final shift: start bit (zero) sits at the leftmost position
    // Stop bit is judged at the end of its time, so a start edge with no idle before it is missed
    assign rx_end_bit = rx_bit;
    assign rx_accept = (rx_state_reg == RX_BITS) & tick.rx_tick & (rx_div_reg == atsp_pkg::BIT_LAST)
                       & ~rx_shift_reg[8] & ~rx_done_flag
                       & (~multiproc_check_enable | rx_end_bit);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_state_reg <= RX_HUNT;
            rx_div_reg <= 4'h0;
            rx_shift_reg <= atsp_pkg::RX_PRELOAD;
        end
        else if (tick.rx_tick)
        begin
            rx_div_reg <= rx_div_reg + 4'h1;
            unique case (rx_state_reg)
                RX_HUNT:
                    if (rx_enable && rxd_prev_reg && !rxd_sync_reg[1])
                    begin
                        rx_div_reg <= 4'h0;
                        rx_shift_reg <= atsp_pkg::RX_PRELOAD;
                        rx_state_reg <= RX_START;
                    end
                RX_START:
                    if (rx_div_reg == atsp_pkg::BIT_LAST)
                    begin
                        if (rx_bit)
                            rx_state_reg <= RX_HUNT;
                        else
                        begin
                            rx_shift_reg <= {rx_shift_reg[7:0], 1'b0};
                            rx_state_reg <= RX_BITS;
                        end
                    end
                RX_BITS:
                    if (rx_div_reg == atsp_pkg::BIT_LAST)
                    begin
                        rx_shift_reg <= {rx_shift_reg[7:0], rx_bit};
                        if (!rx_shift_reg[8])
                            rx_state_reg <= RX_HUNT;
                    end
                default:
                    rx_state_reg <= RX_HUNT;
            endcase
        end
    end

    // First data bit sits highest after the left shifts; the line sends LSB first
    logic [7:0] rx_byte;
    for (genvar i = 0; i < 8; i++)
    begin : g_rx_order
        assign rx_byte[i] = rx_shift_reg[7 - i];
    end

    // Buffer takes the data byte from the final shift
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            serial_data_buffer <= 8'h00;
        else if (rx_accept)
            serial_data_buffer <= rx_byte;
    end
endmodule
`default_nettype wire

// File: tb/atsp_remote.sv
// Remote serial end: sends frames, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module atsp_remote
(
    // Clock and bit length in cycles
    input wire logic clk_i,
    input wire logic [7:0] bit_cyc_i,
    // Serial lines
    input wire logic txd_i,
    output logic rxd_o,
    // Last decoded frame
    output logic [9:0] frame_o
);
    logic [9:0] sh;
    // Line has a pull-up, so it idles high
    initial
    begin
        rxd_o = 1'b1;
        frame_o = 10'h0;
    end
    task automatic send(input logic [7:0] b, input logic stp);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd_o <= f[i];
            repeat (bit_cyc_i) @(posedge clk_i);
        end
        // One idle bit, so the next start bit always makes a falling edge
        rxd_o <= 1'b1;
        repeat (bit_cyc_i) @(posedge clk_i);
    endtask
    task automatic glitch(input int n);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask
    // Mid-bit sampling tolerates the start rollover delay
    always
    begin
        @(negedge txd_i);
        repeat (bit_cyc_i / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            sh[i] = txd_i;
            if (i < 9)
                repeat (bit_cyc_i) @(posedge clk_i);
        end
        frame_o = sh;
    end
endmodule
`default_nettype wire

// File: tb/atsp_sva.sv
// Port-level checks of the serial port
`timescale 1ns/1ps
`default_nettype none
module atsp_sva
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Line and interrupts
    input wire logic txd_o,
    input wire logic irq_o,
    input wire logic serial_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    assign req = cyc_i && stb_i && !ack_o;
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_wait: assert property (req |=> ack_o)
        else $error("ack missing after request");
    a_no_stray: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_unmap_zero: assert property (req && !we_i && adr_i[1:0] != 2'h0 |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_dat_hold: assert property (!(req && !we_i) |=> $stable(dat_o))
        else $error("read data moved without a read");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_reset_idle: assert property (disable iff (1'b0) rst_i |=> txd_o && !irq_o && !serial_irq_o)
        else $error("outputs not idle after reset");
    a_bit_min: assert property ($changed(txd_o) |=> $stable(txd_o) [*7])
        else $error("line bit shorter than its oversample span");
    cover property (ack_o && !we_i);
    cover property ($fell(txd_o));
    cover property ($rose(serial_irq_o));
    cover property ($rose(irq_o));
endmodule
bind atsp_uart atsp_sva chk_u
(
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .txd_o(txd_o), .irq_o(irq_o), .serial_irq_o(serial_irq_o)
);
`default_nettype wire

// File: tb/testbench.sv
// Register-level tests of the ten-bit serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [3:0] A_D = atsp_pkg::ADDR_DATA;
    localparam logic [3:0] A_C = atsp_pkg::ADDR_CTRL;
    localparam logic [3:0] A_S = atsp_pkg::ADDR_IRQ_STAT;
    localparam logic [3:0] A_M = atsp_pkg::ADDR_IRQ_MASK;
    localparam logic [31:0] TXF = 32'h1 << atsp_pkg::CTRL_TX_DONE;
    localparam logic [31:0] RXF = 32'h1 << atsp_pkg::CTRL_RX_DONE;
    localparam logic [31:0] NIN = 32'h1 << atsp_pkg::CTRL_NINTH;
    localparam logic [31:0] MP = 32'h1 << atsp_pkg::CTRL_MPROC;
    localparam logic [31:0] REN = 32'h1 << atsp_pkg::CTRL_REN;
    localparam logic [31:0] DBL = 32'h1 << atsp_pkg::CTRL_DBL;
    localparam logic [31:0] SRC = (32'h1 << atsp_pkg::CTRL_TX_SRC) | (32'h1 << atsp_pkg::CTRL_RX_SRC);
    localparam logic [31:0] RXS = 32'h1 << atsp_pkg::CTRL_RX_SRC;
    logic clk, rst, cyc, stb, we, t1, t2, rxd, txd, ack, irq, sirq;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, q, mode;
    logic [9:0] frame;
    logic [7:0] bitc;
    logic [1:0] tk;
    int errors, cmp_count;
    atsp_uart dut_u
    (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .t1_ovf_i(t1), .t2_ovf_i(t2), .rxd_i(rxd),
        .txd_o(txd), .irq_o(irq), .serial_irq_o(sirq)
    );
    atsp_remote rem_u (.clk_i(clk), .bit_cyc_i(bitc), .txd_i(txd), .rxd_o(rxd), .frame_o(frame));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Timer 2 overflows at half the timer 1 rate
    always @(posedge clk)
    begin
        tk <= tk + 2'h1;
        t1 <= tk[0];
        t2 <= tk == 2'h3;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, ack}, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic wirq();
        for (int n = 0; n < 4000 && sirq !== 1'b1; n++)
            @(posedge clk);
        chk({31'h0, sirq}, 32'h1);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        errors++;
        report_and_stop();
    end
    initial
    begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'hF;
        wdat = 32'h0; tk = 2'h0; t1 = 1'b0; t2 = 1'b0; errors = 0; cmp_count = 0; bitc = 8'h40;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({31'h0, txd}, 32'h1);
        rd(A_C, 32'h0);
        rd(4'h2, 32'h0);
        wr(A_M, 32'h3);
        // Last pass splits the timers: transmit on timer 1, receive on timer 2
        for (int m = 0; m < 5; m++)
        begin
            mode = REN | (m[1] ? SRC : 32'h0) | (m[0] ? DBL : 32'h0) | (m[2] ? RXS : 32'h0);
            bitc = (m[1] ? 8'h80 : 8'h40) >> m[0];
            wr(A_C, mode);
            wr(A_D, 32'h5A + m);
            wirq();
            repeat (bitc) @(posedge clk);
            chk({22'h0, frame}, {23'h1, 8'h5A + 8'(m), 1'b0});
            rd(A_C, mode | TXF);
            chk({31'h0, irq}, 32'h1);
            wr(A_C, mode);
            chk({31'h0, sirq}, 32'h0);
            wr(A_S, 32'h3);
            chk({31'h0, irq}, 32'h0);
            if (m[2])
                bitc = 8'h80;
            rem_u.send(8'hC3 ^ 8'(m), 1'b1);
            rd(A_D, {24'h0, 8'hC3 ^ 8'(m)});
            rd(A_C, mode | RXF | NIN);
            wr(A_C, mode);
            wr(A_S, 32'h3);
            $display("mode %0d done", m);
        end
        bitc = 8'h40;
        wr(A_C, REN);
        rem_u.send(8'h11, 1'b1);
        rem_u.send(8'h22, 1'b1);
        rd(A_D, 32'h11);
        wr(A_C, REN);
        rem_u.glitch(8);
        repeat (800) @(posedge clk);
        chk({31'h0, sirq}, 32'h0);
        rem_u.send(8'h33, 1'b0);
        rd(A_D, 32'h33);
        rd(A_C, REN | RXF);
        wr(A_C, REN | MP);
        rem_u.send(8'h44, 1'b0);
        chk({31'h0, sirq}, 32'h0);
        rem_u.send(8'h55, 1'b1);
        rd(A_D, 32'h55);
        wr(A_C, REN | TXF);
        chk({31'h0, sirq}, 32'h1);
        $display("receive checks done");
        report_and_stop();
    end
endmodule
`default_nettype wire
